// File: verification/pic_link_properties.sv
// concurrent checks on the link between the controller and the cpu core end
// assumes one clock for both ends; tb instantiates it beside the link
`timescale 1ns/1ps
module pic_link_properties
   import pic_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // cpu to controller
   input wire logic reg_sel,
   input wire logic reg_write,
   input wire logic [23:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [1:0] cpu_mask,
   // controller to cpu
   input wire logic reg_ack,
   input wire logic [7:0] reg_rdata,
   input wire logic [1:0] irq_level,
   input wire logic [3:0] irq_vector,
   input wire logic nmi_req
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   AST_ACK_FOLLOWS: assert property (reg_sel |=> reg_ack && !reg_sel)
      else $error("access not acknowledged one cycle later");
   AST_ACK_CAUSE: assert property (reg_ack |-> $past(reg_sel))
      else $error("acknowledge without an access");
   AST_RDATA_HOLD: assert property (!reg_ack |-> $stable(reg_rdata))
      else $error("read data moved between accesses");
   AST_PRIO_B_RSVD: assert property (reg_sel && !reg_write && reg_addr == REG_PRIO_B
      |=> reg_rdata[7:4] == 4'h0)
      else $error("unused priority bits read as one");
   AST_TOP_BIT_RSVD: assert property (reg_sel && !reg_write &&
      (reg_addr == REG_EN_A || reg_addr == REG_PEND_A) |=> !reg_rdata[7])
      else $error("unused top bit reads as one");
   AST_UNMAPPED: assert property (reg_sel && !reg_write && reg_addr > REG_PEND_B
      |=> reg_rdata == 8'h00)
      else $error("unmapped address returned data");
   AST_NO_REQ_VECTOR: assert property (irq_level == 2'h0 |-> irq_vector == 4'h0)
      else $error("vector shown without a request");
   AST_VECTOR_RANGE: assert property (irq_vector <= 4'hE)
      else $error("vector order out of range");
   AST_MASK_BLOCK: assert property (irq_level != 2'h0 && $stable(cpu_mask) &&
      cpu_mask == $past(cpu_mask, 2) && cpu_mask == $past(cpu_mask, 3) |-> irq_level >= cpu_mask)
      else $error("request below mask level passed");
   AST_NMI_PULSE: assert property (nmi_req |=> !nmi_req)
      else $error("watchdog request longer than one cycle");
endmodule : pic_link_properties

// File: verification/tb.sv
// self-checking bench: both ends joined by the link, AHB-Lite master on the cpu end
// assumes one clock and no wait states beyond what hreadyout shows
`timescale 1ns/1ps
module tb
   import pic_pkg::*;
;
   localparam int HOLD = 20;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [SRC_N-1:0] src_event = 15'h0;
   logic wdt_event = 1'b0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [31:0] rd;
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;

   always #50 hclk = ~hclk;

   pic_link_if link ();
   pic_device_end i_pic_device_end (.hclk(hclk), .hresetn(hresetn), .src_event(src_event),
      .wdt_event(wdt_event), .link(link));
   pic_cpu_end #(.SLEEP_HOLD_CYCLES(HOLD)) i_pic_cpu_end (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .link(link));
   pic_link_properties i_pic_link_properties (.hclk(hclk), .hresetn(hresetn),
      .reg_sel(link.reg_sel), .reg_write(link.reg_write), .reg_addr(link.reg_addr),
      .reg_wdata(link.reg_wdata), .cpu_mask(link.cpu_mask), .reg_ack(link.reg_ack),
      .reg_rdata(link.reg_rdata), .irq_level(link.irq_level), .irq_vector(link.irq_vector),
      .nmi_req(link.nmi_req));

   task wrap_up;
      if (errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         errors++;
      end
   endtask : chk

   // one single transfer; read data lands in rd
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb

   // device register access relayed over the link; polls until done
   task dev(input logic w, input logic [23:0] a, input logic [7:0] d);
      ahb(1'b1, w ? HOST_CMD_WRITE : HOST_CMD_READ, {a, d});
      rd = 32'h0;
      while (rd[RESULT_DONE_BIT] !== 1'b1 || rd[RESULT_BUSY_BIT] !== 1'b0)
         ahb(1'b0, HOST_RESULT, 32'h0);
   endtask : dev

   task dchk(input logic [23:0] a, input logic [7:0] e);
      dev(1'b0, a, 8'h00);
      chk({24'h0, rd[7:0]}, {24'h0, e});
   endtask : dchk

   task ev(input logic [SRC_N-1:0] m);
      @(posedge hclk);
      src_event <= m;
      @(posedge hclk);
      src_event <= 15'h0;
   endtask : ev

   task t_reset;
      for (int i = 0; i < 7; i++)
         dchk(REG_PRIO_A + 24'(i), 8'h00);
      ahb(1'b0, HOST_STATUS, 32'h0);
      chk(rd, 32'h0002_0000);
      ahb(1'b0, 8'h18, 32'h0);
      chk(rd, 32'h0);
   endtask : t_reset

   // flags latch with every enable off, then clear by writing ones
   task t_flags;
      ev(15'h5AC0);
      dchk(REG_PEND_A, 8'h5A);
      dchk(REG_PEND_B, 8'hC0);
      ahb(1'b0, HOST_STATUS, 32'h0);
      chk({30'h0, rd[1:0]}, 32'h0);
      dev(1'b1, REG_PEND_A, 8'h10);
      dchk(REG_PEND_A, 8'h4A);
      dev(1'b1, REG_PEND_B, 8'h00);
      dchk(REG_PEND_B, 8'hC0);
      dev(1'b1, REG_PEND_B, 8'hC0);
      dev(1'b1, REG_PEND_A, 8'hFF);
      dchk(REG_PEND_B, 8'h00);
      dchk(REG_PEND_A, 8'h00);
   endtask : t_flags

   task t_regs;
      logic [23:0] ta[4];
      logic [7:0] te[4];
      ta = '{REG_PRIO_A, REG_PRIO_B, REG_EN_A, REG_EN_B};
      te = '{8'hFF, 8'h0F, 8'h7F, 8'hFF};
      for (int i = 0; i < 4; i++)
      begin
         dev(1'b1, ta[i], 8'hFF);
         dchk(ta[i], te[i]);
      end
   endtask : t_regs

   // every level code of the timer group against mask levels 0 and 2
   task t_prio;
      logic [1:0] e;
      for (int m = 0; m < 4; m += 2)
      begin
         ahb(1'b1, HOST_CTRL, 32'(m));
         for (int l = 0; l < 4; l++)
         begin
            dev(1'b1, REG_PRIO_B, {4'h0, 2'(l), 2'h0});
            ev(15'h0080);
            repeat (3) @(posedge hclk);
            ahb(1'b0, HOST_STATUS, 32'h0);
            e = (l != 0 && l >= m) ? 2'(l) : 2'h0;
            chk({16'h0, rd[15:0]}, {16'h0, (e != 2'h0) ? 8'h06 : 8'h00, 6'h0, e});
            dev(1'b1, REG_PEND_B, 8'h80);
         end
      end
   endtask : t_prio

   // higher group level wins across groups; equal levels go to the earlier vector slot
   task t_arb;
      ahb(1'b1, HOST_CTRL, 32'h0);
      dev(1'b1, REG_PRIO_A, 8'h6C);
      ev(15'h310A);
      dchk(REG_PEND_A, 8'h31);
      ahb(1'b0, HOST_STATUS, 32'h0);
      chk({16'h0, rd[15:0]}, 32'h0000_1827);
      dev(1'b1, REG_PEND_A, 8'h7F);
      ahb(1'b0, HOST_STATUS, 32'h0);
      chk({16'h0, rd[15:0]}, 32'h0000_121A);
      dev(1'b1, REG_PEND_B, 8'hFF);
   endtask : t_arb

   // watchdog passes the highest mask; sleep held off for HOLD cycles
   task t_nmi;
      ahb(1'b1, HOST_CTRL, 32'h3);
      @(posedge hclk);
      wdt_event <= 1'b1;
      @(posedge hclk);
      wdt_event <= 1'b0;
      ahb(1'b0, HOST_STATUS, 32'h0);
      chk({30'h0, rd[17:16]}, 32'h1);
      repeat (HOLD + 5) @(posedge hclk);
      ahb(1'b0, HOST_STATUS, 32'h0);
      chk({30'h0, rd[17:16]}, 32'h3);
      ahb(1'b1, HOST_STATUS, 32'h0001_0000);
      ahb(1'b0, HOST_STATUS, 32'h0);
      chk({30'h0, rd[17:16]}, 32'h2);
   endtask : t_nmi

   task t_soft;
      ahb(1'b1, HOST_SOFTVEC, 32'h26);
      ahb(1'b0, HOST_SOFTVEC, 32'h0);
      chk(rd, 32'h26);
      ahb(1'b1, HOST_SOFTVEC, 32'h24);
      chk({31'h0, hresp}, 32'h0);
      ahb(1'b0, HOST_SOFTVEC, 32'h0);
      chk(rd, 32'h126);
      ahb(1'b1, HOST_SOFTVEC, 32'h27);
      ahb(1'b0, HOST_SOFTVEC, 32'h0);
      chk(rd, 32'h126);
   endtask : t_soft

   always @(posedge hclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         errors++;
         wrap_up;
      end
   end

   initial
   begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_flags;
      t_regs;
      t_prio;
      t_arb;
      t_nmi;
      t_soft;
      wrap_up;
   end
endmodule : tb

// File: verilog/pic_arbiter.sv
// picks the highest-level pending source, earliest vector slot on a tie
// purely combinational; the caller registers the result
`timescale 1ns/1ps
module pic_arbiter
   import pic_pkg::*;
(
   // pending and enabled sources
   input wire logic [SRC_N-1:0] active,
   // group levels
   input wire logic [7:0] prio_a,
   input wire logic [PRIO_B_W-1:0] prio_b,
   // winner
   output pic_level_t best_level,
   output logic [3:0] best_order
);

   logic [3:0] src;
   pic_level_t lvl;

   // scan from the last vector slot upward so the earliest slot wins ties
   always_comb
   begin
      best_level = PIC_LVL0;
      best_order = 4'h0;
      src = 4'h0;
      lvl = PIC_LVL0;
      for (int o = SRC_N - 1; o >= 0; o--)
      begin
         src = pic_order_to_src(4'(o));
         lvl = pic_src_level(src, prio_a, prio_b);
         if (active[src] && (lvl != PIC_LVL0) && (lvl >= best_level))
         begin
            best_level = lvl;
            best_order = 4'(o);
         end
      end
   end

endmodule : pic_arbiter

// File: verilog/pic_cpu_end.sv
// cpu-core side of the interrupt link: AHB-Lite slave that holds the mask,
// relays register accesses to the controller and reports requests
// assumes a single AHB-Lite master issuing whole-word single transfers
`timescale 1ns/1ps
module pic_cpu_end
   import pic_pkg::*;
#(
   parameter int SLEEP_HOLD_CYCLES = NMI_SLEEP_CYCLES
)
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // link to the controller
   pic_link_if.cpu link
);

   typedef struct packed {
      logic hreadyout;
      logic [31:0] hrdata;
      logic wr_pend;
      logic rd_pend;
      logic [7:0] addr;
      logic cpu_mask_hi;
      logic cpu_mask_lo;
      pic_acc_state_t acc;
      logic sel;
      logic write;
      logic [23:0] link_addr;
      logic [7:0] link_wdata;
      logic [7:0] result;
      logic done;
      logic nmi_seen;
      logic [HOLD_W-1:0] hold;
      logic [7:0] softvec;
      logic softvec_bad;
   } pic_cpu_state_t;

   pic_cpu_state_t state;
   pic_cpu_state_t next_state;
   logic [31:0] rmux;

   always_comb
   begin
      rmux = '0;
      case (state.addr)
         HOST_CTRL: rmux = {30'h0, state.cpu_mask_hi, state.cpu_mask_lo};
         HOST_RESULT:
         begin
            rmux[7:0] = state.result;
            rmux[RESULT_DONE_BIT] = state.done;
            rmux[RESULT_BUSY_BIT] = (state.acc != PIC_ACC_IDLE);
         end
         HOST_STATUS:
         begin
            rmux[1:0] = link.irq_level;
            rmux[STAT_VECTOR_LSB +: 4] = link.irq_vector;
            if (link.irq_level != 2'h0)
               rmux[STAT_VADDR_LSB +: 8] = pic_vector_addr(link.irq_vector);
            rmux[STAT_NMI_BIT] = state.nmi_seen;
            rmux[STAT_SLEEP_OK_BIT] = (state.hold == '0);
         end
         HOST_SOFTVEC:
         begin
            rmux[7:0] = state.softvec;
            rmux[SOFTVEC_BAD_BIT] = state.softvec_bad;
         end
         default: rmux = '0;
      endcase
   end

   always_comb
   begin
      next_state = state;
      next_state.wr_pend = 1'b0;

      // reads take one wait state so a write just before is visible
      if (state.rd_pend)
      begin
         next_state.hrdata = rmux;
         next_state.hreadyout = 1'b1;
         next_state.rd_pend = 1'b0;
      end

      if (state.hold != '0)
         next_state.hold = HOLD_W'(state.hold - 1'b1);
      if (link.nmi_req)
         next_state.hold = HOLD_W'(SLEEP_HOLD_CYCLES);

      if (state.wr_pend)
      begin
         case (state.addr)
            HOST_CTRL:
            begin
               next_state.cpu_mask_hi = hwdata[1];
               next_state.cpu_mask_lo = hwdata[0];
            end
            HOST_CMD_WRITE, HOST_CMD_READ:
            begin
               // enables are forwarded only when software asks, after its setup
               if (state.acc == PIC_ACC_IDLE)
               begin
                  next_state.acc = PIC_ACC_REQ;
                  next_state.sel = 1'b1;
                  next_state.write = (state.addr == HOST_CMD_WRITE);
                  next_state.link_addr = hwdata[CMD_ADDR_LSB +: 24];
                  next_state.link_wdata = hwdata[7:0];
                  next_state.done = 1'b0;
               end
            end
            HOST_STATUS:
            begin
               if (hwdata[STAT_NMI_BIT])
                  next_state.nmi_seen = 1'b0;
            end
            HOST_SOFTVEC:
            begin
               if (hwdata[0] || hwdata[7:0] < VEC_SOFT_LO || hwdata[7:0] > VEC_SOFT_HI)
                  next_state.softvec_bad = 1'b1;
               else
               begin
                  next_state.softvec = hwdata[7:0];
                  next_state.softvec_bad = 1'b0;
               end
            end
            default:
            begin
               next_state.wr_pend = 1'b0;
            end
         endcase
      end

      // set wins over the software clear
      if (link.nmi_req)
         next_state.nmi_seen = 1'b1;

      case (state.acc)
         PIC_ACC_IDLE: next_state.sel = next_state.sel;
         PIC_ACC_REQ:
         begin
            next_state.sel = 1'b0;
            next_state.acc = PIC_ACC_WAIT;
         end
         PIC_ACC_WAIT:
         begin
            if (link.reg_ack)
            begin
               next_state.result = link.reg_rdata;
               next_state.done = 1'b1;
               next_state.acc = PIC_ACC_IDLE;
            end
         end
         default: next_state.acc = PIC_ACC_IDLE;
      endcase

      if (hsel && hready && htrans[1])
      begin
         next_state.addr = haddr[7:0];
         next_state.wr_pend = hwrite;
         if (!hwrite)
         begin
            next_state.rd_pend = 1'b1;
            next_state.hreadyout = 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= '0;
         state.hreadyout <= 1'b1;
         state.acc <= PIC_ACC_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign hreadyout = state.hreadyout;
   assign hresp = 1'b0;
   assign hrdata = state.hrdata;
   assign link.reg_sel = state.sel;
   assign link.reg_write = state.write;
   assign link.reg_addr = state.link_addr;
   assign link.reg_wdata = state.link_wdata;
   assign link.cpu_mask = {state.cpu_mask_hi, state.cpu_mask_lo};

endmodule : pic_cpu_end

// File: verilog/pic_device_end.sv
// peripheral interrupt controller: priority, enable and pending registers,
// request to the cpu core and watchdog pass-through
// assumes source events and the watchdog event are one-cycle pulses on hclk
`timescale 1ns/1ps
module pic_device_end
   import pic_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // source events, one bit per source
   input wire logic [SRC_N-1:0] src_event,
   input wire logic wdt_event,
   // link to the cpu core
   pic_link_if.dev link
);

   typedef struct packed {
      logic [7:0] prio_a;
      logic [PRIO_B_W-1:0] prio_b;
      logic [PEND_A_W-1:0] en_a;
      logic [7:0] en_b;
      logic [SRC_N-1:0] pending;
      logic [7:0] rdata;
      logic ack;
      pic_level_t level;
      logic [3:0] vector;
      logic nmi;
   } pic_dev_state_t;

   pic_dev_state_t state;
   pic_dev_state_t next_state;

   logic [SRC_N-1:0] clear;
   logic [SRC_N-1:0] enables;
   logic [SRC_N-1:0] active;
   pic_level_t best_level;
   logic [3:0] best_order;

   // unused high bits of the narrow registers read as zero
   function automatic logic [7:0] read_reg(input logic [23:0] addr, input pic_dev_state_t s);
      case (addr)
         REG_PRIO_A: return s.prio_a;
         REG_PRIO_B: return {{(8 - PRIO_B_W){1'b0}}, s.prio_b};
         REG_EN_A: return {1'b0, s.en_a};
         REG_EN_B: return s.en_b;
         REG_PEND_A: return {1'b0, s.pending[PEND_A_LSB +: PEND_A_W]};
         REG_PEND_B: return s.pending[7:0];
         default: return REG_RESET;
      endcase
   endfunction : read_reg

   assign enables = {state.en_a, state.en_b};

   // flag only requests while its own enable is on
   assign active = state.pending & enables;

   pic_arbiter i_pic_arbiter (
      .active(active),
      .prio_a(state.prio_a),
      .prio_b(state.prio_b),
      .best_level(best_level),
      .best_order(best_order)
   );

   always_comb
   begin
      next_state = state;
      clear = '0;
      next_state.ack = 1'b0;

      if (link.reg_sel && link.reg_write)
      begin
         case (link.reg_addr)
            REG_PRIO_A:
            begin
               next_state.prio_a = link.reg_wdata;
            end
            REG_PRIO_B:
            begin
               next_state.prio_b = link.reg_wdata[PRIO_B_W-1:0];
            end
            REG_EN_A:
            begin
               next_state.en_a = link.reg_wdata[PEND_A_W-1:0];
            end
            REG_EN_B:
            begin
               next_state.en_b = link.reg_wdata;
            end
            REG_PEND_A:
            begin
               // a zero written leaves the flag alone
               clear[PEND_A_LSB +: PEND_A_W] = link.reg_wdata[PEND_A_W-1:0];
            end
            REG_PEND_B:
            begin
               clear[7:0] = link.reg_wdata;
            end
            default:
            begin
               clear = '0;
            end
         endcase
      end

      // every access is answered one cycle later, writes return the old value
      if (link.reg_sel)
      begin
         next_state.ack = 1'b1;
         next_state.rdata = read_reg(link.reg_addr, state);
      end

      // set wins over clear so an event in the clearing cycle is kept;
      // flags latch regardless of enable or cpu mask so software can poll
      next_state.pending = (state.pending & ~clear) | src_event;

      // a level under the cpu mask is held back, not dropped: the flag stays
      if (best_level < pic_level_t'(link.cpu_mask))
      begin
         next_state.level = PIC_LVL0;
         next_state.vector = 4'h0;
      end
      else
      begin
         next_state.level = best_level;
         next_state.vector = (best_level == PIC_LVL0) ? 4'h0 : best_order;
      end

      // watchdog goes straight through, no enable and no mask
      next_state.nmi = wdt_event;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state.prio_a <= REG_RESET;
         state.prio_b <= '0;
         state.en_a <= '0;
         state.en_b <= '0;
         state.pending <= '0;
         state.rdata <= REG_RESET;
         state.ack <= 1'b0;
         state.level <= PIC_LVL0;
         state.vector <= 4'h0;
         state.nmi <= 1'b0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign link.reg_ack = state.ack;
   assign link.reg_rdata = state.rdata;
   assign link.irq_level = state.level;
   assign link.irq_vector = state.vector;
   assign link.nmi_req = state.nmi;

endmodule : pic_device_end

// File: verilog/pic_link_if.sv
// link between the interrupt controller and the cpu core's interrupt logic
// assumes both ends run on the same clock; no clocking block
`timescale 1ns/1ps
interface pic_link_if;
   // register access, cpu to controller
   logic reg_sel;
   logic reg_write;
   logic [23:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [1:0] cpu_mask;
   // answers and requests, controller to cpu
   logic reg_ack;
   logic [7:0] reg_rdata;
   logic [1:0] irq_level;
   logic [3:0] irq_vector;
   logic nmi_req;

   modport dev (
      input reg_sel, reg_write, reg_addr, reg_wdata, cpu_mask,
      output reg_ack, reg_rdata, irq_level, irq_vector, nmi_req
   );
   modport cpu (
      output reg_sel, reg_write, reg_addr, reg_wdata, cpu_mask,
      input reg_ack, reg_rdata, irq_level, irq_vector, nmi_req
   );
endinterface : pic_link_if

// File: verilog/pic_pkg.sv
// constants, types and helpers shared by both ends of the peripheral interrupt link
// assumes one 10 MHz clock for both ends and an AHB-Lite master in front of the cpu end
//
// What this block does
// - first priority register: four two-bit group levels
// - second register: timer bits 3:2, K1 1:0
// - level codes: 11=3, 10=2, 01=1, 00=0
// - one enable bit per stopwatch/clock source
// - enable bits for timers, K ports, serial
// - flags latch events; write one clears
// - timer 1 flag bit 7, timer 0 bit 6
// - stopwatch/clock flag bit positions fixed
// - flags set regardless of enables or mask
// - watchdog request ignores enables and mask
// - requests below cpu mask level blocked
// - software vectors even, 26h to FEh
// - vector bytes 24h and 25h never used
// - no sleep for 2 msec after watchdog
// - set up sources before enabling them
package pic_pkg;

   localparam int SRC_N = 15;

   // device register map
   localparam logic [23:0] REG_PRIO_A = 24'h00FF20;
   localparam logic [23:0] REG_PRIO_B = 24'h00FF21;
   localparam logic [23:0] REG_EN_A = 24'h00FF22;
   localparam logic [23:0] REG_EN_B = 24'h00FF23;
   localparam logic [23:0] REG_PEND_A = 24'h00FF24;
   localparam logic [23:0] REG_PEND_B = 24'h00FF25;
   localparam logic [7:0] REG_RESET = 8'h00;

   // priority field positions
   localparam int PRIO_KPORT0_LSB = 6;
   localparam int PRIO_SERIAL_LSB = 4;
   localparam int PRIO_STOPWATCH_LSB = 2;
   localparam int PRIO_CLOCKTIMER_LSB = 0;
   localparam int PRIO_PROGTIMER_LSB = 2;
   localparam int PRIO_KPORT1_LSB = 0;

   // source numbering: bits 7..0 are pending_ports_serial, 14..8 pending_timers_a
   localparam logic [3:0] SRC_SERIAL_TX = 4'h0;
   localparam logic [3:0] SRC_SERIAL_RX = 4'h1;
   localparam logic [3:0] SRC_SERIAL_ERR = 4'h2;
   localparam logic [3:0] SRC_KPORT0_LO = 4'h3;
   localparam logic [3:0] SRC_KPORT0_HI = 4'h4;
   localparam logic [3:0] SRC_KPORT1 = 4'h5;
   localparam logic [3:0] SRC_PROGTIMER0 = 4'h6;
   localparam logic [3:0] SRC_PROGTIMER1 = 4'h7;
   localparam logic [3:0] SRC_CLOCK_1HZ = 4'h8;
   localparam logic [3:0] SRC_CLOCK_2HZ = 4'h9;
   localparam logic [3:0] SRC_CLOCK_8HZ = 4'hA;
   localparam logic [3:0] SRC_CLOCK_32HZ = 4'hB;
   localparam logic [3:0] SRC_SW_1HZ = 4'hC;
   localparam logic [3:0] SRC_SW_10HZ = 4'hD;
   localparam logic [3:0] SRC_SW_100HZ = 4'hE;
   localparam int PEND_A_LSB = 8;
   localparam int PEND_A_W = 7;
   localparam int PRIO_B_W = 4;

   typedef enum logic [1:0] {
      PIC_LVL0 = 2'h0,
      PIC_LVL1 = 2'h1,
      PIC_LVL2 = 2'h2,
      PIC_LVL3 = 2'h3
   } pic_level_t;

   // vector table
   localparam logic [7:0] VEC_FIRST_PERIPH = 8'h06;
   localparam logic [7:0] VEC_SOFT_LO = 8'h26;
   localparam logic [7:0] VEC_SOFT_HI = 8'hFE;
   localparam logic [7:0] VEC_RESERVED_LO = 8'h24;
   localparam logic [7:0] VEC_RESERVED_HI = 8'h25;
   localparam logic [4:0] ORDER_TIMERS_BASE = 5'h16;
   localparam logic [3:0] ORDER_PORTS_TOP = 4'h7;

   // cpu-end AHB register map and fields
   localparam logic [7:0] HOST_CTRL = 8'h00;
   localparam logic [7:0] HOST_CMD_WRITE = 8'h04;
   localparam logic [7:0] HOST_CMD_READ = 8'h08;
   localparam logic [7:0] HOST_RESULT = 8'h0C;
   localparam logic [7:0] HOST_STATUS = 8'h10;
   localparam logic [7:0] HOST_SOFTVEC = 8'h14;
   localparam int RESULT_DONE_BIT = 8;
   localparam int RESULT_BUSY_BIT = 9;
   localparam int STAT_VECTOR_LSB = 2;
   localparam int STAT_VADDR_LSB = 8;
   localparam int STAT_NMI_BIT = 16;
   localparam int STAT_SLEEP_OK_BIT = 17;
   localparam int SOFTVEC_BAD_BIT = 8;
   localparam int CMD_ADDR_LSB = 8;

   // sleep hold-off after a watchdog request
   localparam int NMI_SLEEP_WAIT_US = 2000;
   localparam int CLK_PERIOD_NS = 100;
   localparam int NMI_SLEEP_CYCLES = NMI_SLEEP_WAIT_US * 1000 / CLK_PERIOD_NS;
   localparam int HOLD_W = 16;

   typedef enum logic [1:0] {
      PIC_ACC_IDLE = 2'h0,
      PIC_ACC_REQ = 2'h1,
      PIC_ACC_WAIT = 2'h2
   } pic_acc_state_t;

   // vector order 0 is programmable timer 1, 14 is clock 1 Hz
   function automatic logic [3:0] pic_order_to_src(input logic [3:0] ord);
      if (ord <= ORDER_PORTS_TOP)
         return 4'(ORDER_PORTS_TOP - ord);
      else
         return 4'(ORDER_TIMERS_BASE - {1'b0, ord});
   endfunction : pic_order_to_src

   function automatic logic [7:0] pic_vector_addr(input logic [3:0] ord);
      return 8'(VEC_FIRST_PERIPH + {3'h0, ord, 1'b0});
   endfunction : pic_vector_addr

   function automatic pic_level_t pic_src_level(input logic [3:0] src, input logic [7:0] prio_a,
                                                input logic [PRIO_B_W-1:0] prio_b);
      case (src)
         SRC_PROGTIMER1, SRC_PROGTIMER0: return pic_level_t'(prio_b[PRIO_PROGTIMER_LSB +: 2]);
         SRC_KPORT1: return pic_level_t'(prio_b[PRIO_KPORT1_LSB +: 2]);
         SRC_KPORT0_HI, SRC_KPORT0_LO: return pic_level_t'(prio_a[PRIO_KPORT0_LSB +: 2]);
         SRC_SERIAL_ERR, SRC_SERIAL_RX, SRC_SERIAL_TX:
            return pic_level_t'(prio_a[PRIO_SERIAL_LSB +: 2]);
         SRC_SW_100HZ, SRC_SW_10HZ, SRC_SW_1HZ:
            return pic_level_t'(prio_a[PRIO_STOPWATCH_LSB +: 2]);
         default: return pic_level_t'(prio_a[PRIO_CLOCKTIMER_LSB +: 2]);
      endcase
   endfunction : pic_src_level

endpackage : pic_pkg
